// file: core/bmfr_regs.v
// Initial channel-availability registers and fairness priority limiter.
// Assumes a 100 MHz clock, an Avalon-MM master and synchronous resets.
// Functional notes
// - Both initial channel words reset to all ones on hard or soft reset.
// - Bus reset leaves both initial channel-availability words unchanged.
// - Global, PCI or bus reset copies upper initial word to live CSR.
// - Global, PCI or bus reset copies lower initial word to live CSR.
// - Fairness bits 31..8 read zero, ignore writes; register resets to zero.
// - Fairness bits 7..0 limit priority requests per fairness interval.
`timescale 1ns/1ps
`default_nettype none
`include "bmfr_defines.vh"

module bmfr_regs (
  // Clock and resets
  input  wire        i_mclk,
  input  wire        i_rst_n,
  input  wire        i_soft_rst,
  input  wire        i_pci_rst,
  input  wire        i_bus_rst,
  // Avalon-MM slave
  input  wire [7:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  // Live bus-management CSRs
  output reg  [31:0] o_chan_avail_hi,
  output reg  [31:0] o_chan_avail_lo,
  // Priority arbitration to PHY
  input  wire        i_pri_req,
  input  wire        i_fair_interval,
  output reg         o_pri_req,
  output reg         o_pri_block
);

  reg  [31:0] init_chan_avail_upper;
  reg  [31:0] init_chan_avail_lower;
  reg  [7:0]  pri_req_limit;
  reg  [7:0]  pri_req_count;
  reg         done;
  wire        access;
  wire        wr_go;
  wire        hard_rst;
  wire        load_live;
  wire        allow;

  // Byte-lane merge
  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge[k*8 +: 8] = dat[k*8 +: 8];
        end
      end
    end
  endfunction

  assign access    = (i_avs_read | i_avs_write) & ~done;
  assign wr_go     = i_avs_write & ~done;
  assign hard_rst  = ~i_rst_n | i_soft_rst;
  assign load_live = i_pci_rst | i_bus_rst;
  assign allow     = (pri_req_count < pri_req_limit);

  // One wait state, then acknowledge
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      done              <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= `BMFR_READ_ZERO;
    end else begin
      done              <= access;
      o_avs_waitrequest <= ~access;
      if (access && i_avs_read) begin
        case (i_avs_address)
          `BMFR_OFF_CHAN_UPPER: o_avs_readdata <= init_chan_avail_upper;
          `BMFR_OFF_CHAN_LOWER: o_avs_readdata <= init_chan_avail_lower;
          `BMFR_OFF_FAIRNESS:
            o_avs_readdata <= {`BMFR_FAIR_PAD, pri_req_limit};
          default: o_avs_readdata <= `BMFR_READ_ZERO;
        endcase
      end
    end
  end

  // Initial value registers
  always @(posedge i_mclk) begin
    if (hard_rst) begin
      init_chan_avail_upper <= `BMFR_CHAN_RESET;
      init_chan_avail_lower <= `BMFR_CHAN_RESET;
      pri_req_limit         <= `BMFR_FAIR_RESET;
    end else if (wr_go) begin
      // Bus reset does not touch these
      if (i_avs_address == `BMFR_OFF_CHAN_UPPER) begin
        init_chan_avail_upper <= merge(init_chan_avail_upper,
                                       i_avs_writedata, i_avs_byteenable);
      end
      if (i_avs_address == `BMFR_OFF_CHAN_LOWER) begin
        init_chan_avail_lower <= merge(init_chan_avail_lower,
                                       i_avs_writedata, i_avs_byteenable);
      end
      if (i_avs_address == `BMFR_OFF_FAIRNESS && i_avs_byteenable[0]) begin
        pri_req_limit <= i_avs_writedata[`BMFR_FAIR_MSB:0];
      end
    end
  end

  // Live CSRs load from initial values
  always @(posedge i_mclk) begin
    if (hard_rst) begin
      o_chan_avail_hi <= `BMFR_CHAN_RESET;
      o_chan_avail_lo <= `BMFR_CHAN_RESET;
    end else if (load_live) begin
      o_chan_avail_hi <= init_chan_avail_upper;
      o_chan_avail_lo <= init_chan_avail_lower;
    end
  end

  // Fairness limiter
  always @(posedge i_mclk) begin
    if (hard_rst) begin
      pri_req_count <= `BMFR_CNT_RESET;
      o_pri_req     <= 1'b0;
      o_pri_block   <= 1'b1;
    end else begin
      o_pri_req <= i_pri_req & allow & ~i_fair_interval & ~load_live;
      if (i_fair_interval || load_live) begin
        pri_req_count <= `BMFR_CNT_RESET;
        o_pri_block   <= (pri_req_limit == `BMFR_CNT_RESET);
      end else begin
        if (i_pri_req && allow) begin
          pri_req_count <= pri_req_count + 8'h01;
        end
        o_pri_block <= ~allow | (i_pri_req && allow &&
                       (pri_req_count + 8'h01 == pri_req_limit));
      end
    end
  end

endmodule
`default_nettype wire

// file: shared/bmfr_defines.vh
// Constants for the bus-management initial value and fairness registers.
// Assumes inclusion by core/bmfr_regs.v only.
`ifndef BMFR_DEFINES_VH
`define BMFR_DEFINES_VH

// Register byte offsets
`define BMFR_OFF_CHAN_UPPER   8'hB4
`define BMFR_OFF_CHAN_LOWER   8'hB8
`define BMFR_OFF_FAIRNESS     8'hDC

// Reset values
`define BMFR_CHAN_RESET       32'hFFFFFFFF
`define BMFR_FAIR_RESET       8'h00
`define BMFR_CNT_RESET        8'h00

// Field layout
`define BMFR_FAIR_MSB         7
`define BMFR_FAIR_PAD         24'h000000
`define BMFR_READ_ZERO        32'h00000000
`define BMFR_ADDR_W           8

`endif

// file: bench/bmfr_regs_assertions.sv
// Port checker for the channel and fairness register block.
// Assumes it is bound onto bmfr_regs.
`timescale 1ns/1ps
`default_nettype none
module bmfr_chk (
  input wire logic        i_mclk, i_rst_n, i_soft_rst, i_pci_rst, i_bus_rst,
  input wire logic        i_avs_read, i_pri_req, o_avs_waitrequest,
  input wire logic        o_pri_req, o_pri_block,
  input wire logic [7:0]  i_avs_address,
  input wire logic [31:0] o_avs_readdata, o_chan_avail_hi, o_chan_avail_lo
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence no_rst; !(i_bus_rst || i_pci_rst || i_soft_rst); endsequence
  sequence fair_rd; i_avs_read && i_avs_address == 8'hDC; endsequence
  a_wait_one: assert property ($rose(i_avs_read) |=> !o_avs_waitrequest)
    else $error("read not answered");
  a_soft_ones: assert property (i_soft_rst |=> &o_chan_avail_lo)
    else $error("live word not all ones");
  a_hi_hold: assert property (no_rst |=> $stable(o_chan_avail_hi))
    else $error("upper live word moved");
  a_lo_hold: assert property (no_rst |=> $stable(o_chan_avail_lo))
    else $error("lower live word moved");
  a_pad_zero: assert property (fair_rd ##1 !o_avs_waitrequest
    |-> o_avs_readdata[31:8] == 24'h000000) else $error("pad not zero");
  a_blk_drop: assert property (i_pri_req && o_pri_block |=> !o_pri_req)
    else $error("request passed at limit");
  a_req_cause: assert property (o_pri_req |-> $past(i_pri_req))
    else $error("request without cause");
endmodule
bind bmfr_regs bmfr_chk i_chk (.*);
`default_nettype wire

// file: bench/bmfr_regs_tb.sv
// Self-checking bench for the channel and fairness register block.
// Assumes the design and its checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module bmfr_regs_tb;
  logic        i_mclk = 0, i_rst_n = 0, i_soft_rst = 0, i_bus_rst = 0;
  logic        i_avs_read = 0, i_avs_write = 0, i_pri_req = 0;
  logic        i_fair_interval = 0, i_pci_rst = 0;
  logic [7:0]  i_avs_address = 8'h00;
  logic [31:0] i_avs_writedata = 32'h0, rd, o_avs_readdata;
  logic [31:0] o_chan_avail_hi, o_chan_avail_lo;
  logic        o_avs_waitrequest, o_pri_req, o_pri_block;
  int          miscompares = 0, n_tests = 0, npr = 0;
  logic [71:0] rows [4] = '{{8'hB4, 32'h12345678, 32'h12345678},
    {8'hB8, 32'h9ABCDEF0, 32'h9ABCDEF0}, {8'hDC, 32'hFFFFFF05, 32'h00000005},
    {8'h00, 32'h5A5A5A5A, 32'h00000000}};
  bmfr_regs i_dut (.i_avs_byteenable(4'hF), .*);
  initial forever #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (o_pri_req === 1'b1) npr++;
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    {i_avs_write, i_avs_read, i_avs_address, i_avs_writedata} <= {w, !w, a, d};
    do @(posedge i_mclk); while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    {i_avs_write, i_avs_read} <= 2'h0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task pls(input int n);
    repeat (n) begin
      @(posedge i_mclk) i_pri_req <= 1;
      @(posedge i_mclk) i_pri_req <= 0;
    end
  endtask
  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1;
    foreach (rows[k]) begin
      acc(1, rows[k][71:64], rows[k][63:32]);
      acc(0, rows[k][71:64], 32'h0);
      chk(rd, rows[k][31:0]);
    end
    @(posedge i_mclk) i_bus_rst <= 1;
    @(posedge i_mclk) i_bus_rst <= 0;
    @(posedge i_mclk);
    chk(o_chan_avail_hi, 32'h12345678);
    chk(o_chan_avail_lo, 32'h9ABCDEF0);
    acc(0, 8'hB4, 32'h0);
    chk(rd, 32'h12345678);
    acc(1, 8'hB4, 32'h0F0F0F0F);
    chk(o_chan_avail_hi, 32'h12345678);
    @(posedge i_mclk) i_pci_rst <= 1;
    @(posedge i_mclk) i_pci_rst <= 0;
    @(posedge i_mclk);
    chk(o_chan_avail_hi, 32'h0F0F0F0F);
    chk(o_chan_avail_lo, 32'h9ABCDEF0);
    acc(1, 8'hDC, 32'h00000002);
    pls(3);
    chk(o_pri_block, 1'b1);
    @(posedge i_mclk) i_fair_interval <= 1;
    @(posedge i_mclk) i_fair_interval <= 0;
    pls(1);
    repeat (3) @(posedge i_mclk);
    chk(npr, 3);
    chk(o_pri_block, 1'b0);
    @(posedge i_mclk) i_soft_rst <= 1;
    @(posedge i_mclk) i_soft_rst <= 0;
    acc(0, 8'hB8, 32'h0);
    chk(rd, 32'hFFFFFFFF);
    acc(0, 8'hDC, 32'h0);
    chk(rd, 32'h00000000);
    tally_and_finish;
  end
  initial begin
    #20000;
    miscompares++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
